// ===== hw/debounce_tick.sv
// Divider producing the 2 ms debounce-cycle enable pulse
`timescale 1ns/1ps
module debounce_tick
  import keyscan_cfg_pkg::*;
#(
  parameter int STEP_CYC = DEB_STEP_CYC
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  output logic      tick
);
  localparam int CW = $clog2(STEP_CYC);
  logic [CW-1:0] count;
  wire           at_end = (count == CW'(STEP_CYC - 1));

  // Free-running divider; tick is one cycle wide
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      count <= at_end ? '0 : count + 1'b1;
      tick  <= at_end;
    end
  end
endmodule // debounce_tick

// ===== hw/keyscan_config_irq_regs.sv
// Configuration, debounce and interrupt-setup registers with interrupt generation
// Overview of operation
// RQ1: Sleep bit at 0 with constant-current PWM off puts the whole chip into key-switch sleep.
// RQ2: While constant-current PWM is on, keys stay active and all sleep-bit changes are ignored.
// RQ3: With PWM off, host writes, autosleep and autowake all change the sleep bit, readable any time.
// RQ4: Interrupt mode 0 holds the interrupt asserted until the key FIFO is empty.
// RQ5: Interrupt mode 1 drops the interrupt once the host reads the FIFO.
// RQ6: Timeout-disable bit 0 enables the bus timeout, 1 disables it.
// RQ7: Press debounce is low nibble and release is high nibble, each (code+1) x 2 ms.
// RQ8: A nonzero time field N asserts the interrupt every N debounce cycles, zero disables.
// RQ9: A nonzero FIFO field n asserts the interrupt at 2n events, zero disables.
// RQ10: Both interrupt sources may run together and either may assert the output.
// RQ11: The interrupt register resets to zero so both sources start disabled.
// RQ12: Release events are queued only when release enable is set, else presses only.
// RQ13: Keypress wake from sleep only when autowake enable is set; reserved bits are zero.
`timescale 1ns/1ps
module keyscan_config_irq_regs
  import keyscan_cfg_pkg::*;
#(
  parameter int STEP_CYC = DEB_STEP_CYC
) (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire reg_req_t              req,          // Decoded register access from the bus target
  output logic [7:0]                 rdata,
  input  wire logic                  pwm_cc_on,    // Constant-current PWM enable from LED block
  input  wire logic                  autosleep_ev, // One-cycle autosleep timeout
  input  wire logic                  keypress_ev,  // One-cycle debounced keypress
  input  wire logic                  fifo_read,    // Host read of the key FIFO
  input  wire logic [FIFO_CNT_W-1:0] fifo_count,
  output logic                       chip_sleep,
  output logic                       keys_active,
  output logic                       bus_timeout_en,
  output logic                       release_enable,
  output logic [5:0]                 press_deb_ms,
  output logic [5:0]                 release_deb_ms,
  output logic                       debounce_tick_o,
  output logic                       int_n
);
  logic [7:0] device_configuration;
  logic [7:0] debounce_times;
  logic [7:0] interrupt_setup;
  logic       tick;
  logic [4:0] period_cnt;
  logic       int_pend;

  // Debounce time in ms for a 4-bit code
  // Six bits wide so the longest 32 ms setting does not wrap to zero
  function automatic logic [5:0] deb_ms(input logic [3:0] code);
    deb_ms = 6'((code + 6'h01) * DEB_STEP_MS);
  endfunction

  wire cfg_wr   = req.wr && (req.addr == OFF_DEVICE_CONFIGURATION);
  wire deb_wr   = req.wr && (req.addr == OFF_DEBOUNCE_TIMES);
  wire irq_wr   = req.wr && (req.addr == OFF_INTERRUPT_SETUP);
  wire [4:0] time_n = interrupt_setup[4:0];
  wire [2:0] fifo_n = interrupt_setup[7:5];
  wire int_mode = device_configuration[CFG_INTMODE_BIT];
  wire autowake = device_configuration[CFG_AUTOWAKE_BIT];

  debounce_tick #(.STEP_CYC(STEP_CYC)) u_tick (
    .mclk  (mclk),
    .rst_n (rst_n),
    .tick  (tick)
  );

  // Sleep bit value after this cycle's sources; write wins over internal events
  // Autosleep outranks wake so a timeout and a keypress in one cycle leave the chip asleep
  logic next_sleep;
  always_comb begin
    next_sleep = device_configuration[CFG_SLEEP_BIT];
    // RQ13 keypress wake gate
    if (keypress_ev && autowake)
      next_sleep = 1'b1;
    if (autosleep_ev)
      next_sleep = 1'b0;
    // RQ3 host write changes sleep
    if (cfg_wr)
      next_sleep = req.wdata[CFG_SLEEP_BIT];
    // RQ2 PWM freezes sleep bit
    if (pwm_cc_on)
      next_sleep = device_configuration[CFG_SLEEP_BIT];
  end

  // Register writes; reserved bits forced to zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      device_configuration <= RST_DEVICE_CONFIGURATION;
      debounce_times       <= RST_DEBOUNCE_TIMES;
      // RQ11 interrupt setup cleared
      interrupt_setup      <= RST_INTERRUPT_SETUP;
    end else begin
      // RQ13 reserved bits zero
      device_configuration <= ((cfg_wr ? req.wdata : device_configuration) & CFG_WRITE_MASK & 8'h7f)
                              | {next_sleep, 7'h00};
      if (deb_wr)
        debounce_times <= req.wdata;
      if (irq_wr)
        interrupt_setup <= req.wdata;
    end
  end

  // Readback shows current state, including autonomous sleep changes
  assign rdata = (req.addr == OFF_DEVICE_CONFIGURATION) ? device_configuration :
                 (req.addr == OFF_DEBOUNCE_TIMES)       ? debounce_times :
                 (req.addr == OFF_INTERRUPT_SETUP)      ? interrupt_setup : 8'h00;

  // RQ1 sleep shuts chip down
  assign chip_sleep     = !device_configuration[CFG_SLEEP_BIT] && !pwm_cc_on;
  // RQ2 keys kept active
  assign keys_active    = pwm_cc_on || device_configuration[CFG_SLEEP_BIT];
  // RQ6 timeout enable
  assign bus_timeout_en = !device_configuration[CFG_TODIS_BIT];
  // RQ12 release reporting
  assign release_enable = device_configuration[CFG_RELEASE_BIT];
  // RQ7 debounce nibbles
  assign press_deb_ms   = deb_ms(debounce_times[3:0]);
  assign release_deb_ms = deb_ms(debounce_times[7:4]);
  assign debounce_tick_o = tick;

  // RQ8 periodic source
  wire time_hit = (time_n != 5'h00) && tick && (period_cnt == time_n - 5'h01);
  // RQ9 FIFO level source
  wire fifo_hit = (fifo_n != 3'h0) && (fifo_count >= {1'b0, fifo_n, 1'b0});
  // Release condition depends on clearing mode
  wire fifo_empty = (fifo_count == '0);
  // RQ4 RQ5 clearing policy
  wire int_clear  = int_mode ? fifo_read : fifo_empty;

  // Period counter; restarts when the field is rewritten, then wraps every N ticks
  // Limitation: the divider free-runs, so the first interval after a rewrite may be short
  always_ff @(posedge mclk) begin
    if (!rst_n || irq_wr)
      period_cnt <= 5'h00;
    else if (tick)
      period_cnt <= (period_cnt >= time_n - 5'h01) ? 5'h00 : period_cnt + 5'h01;
  end

  // RQ10 either source sets; set wins over clear
  always_ff @(posedge mclk) begin
    if (!rst_n)
      int_pend <= 1'b0;
    else if (time_hit || fifo_hit)
      int_pend <= 1'b1;
    else if (int_clear)
      int_pend <= 1'b0;
  end

  assign int_n = !int_pend;

  // Assertions
  AST_PWM_FREEZE: assert property (@(posedge mclk) disable iff (!rst_n) // RQ2
    pwm_cc_on |=> $stable(device_configuration[CFG_SLEEP_BIT]))
    else $error("Sleep bit changed with PWM on");
  AST_WRITE_SLEEP: assert property (@(posedge mclk) disable iff (!rst_n) // RQ3
    (cfg_wr && !pwm_cc_on) |=> device_configuration[CFG_SLEEP_BIT] == $past(req.wdata[CFG_SLEEP_BIT]))
    else $error("Host write did not set sleep bit");
  AST_SLEEP_OUT: assert property (@(posedge mclk) disable iff (!rst_n) // RQ1
    (cfg_wr && !pwm_cc_on && !req.wdata[CFG_SLEEP_BIT]) |=> chip_sleep == !pwm_cc_on)
    else $error("Sleep output wrong");
  AST_WAKE_GATE: assert property (@(posedge mclk) disable iff (!rst_n) // RQ13
    (keypress_ev && !autowake && !cfg_wr && !device_configuration[CFG_SLEEP_BIT]) |=>
      !device_configuration[CFG_SLEEP_BIT])
    else $error("Woke without autowake");
  AST_HOLD_TILL_EMPTY: assert property (@(posedge mclk) disable iff (!rst_n) // RQ4
    (int_pend && !int_mode && !fifo_empty) |=> int_pend)
    else $error("Interrupt dropped before FIFO empty");
  AST_CLEAR_ON_READ: assert property (@(posedge mclk) disable iff (!rst_n) // RQ5
    (int_pend && int_mode && fifo_read && !time_hit && !fifo_hit) |=> !int_pend)
    else $error("Interrupt not cleared on FIFO read");
  AST_TIMEOUT_EN: assert property (@(posedge mclk) disable iff (!rst_n) // RQ6
    cfg_wr |=> bus_timeout_en == !$past(req.wdata[CFG_TODIS_BIT]))
    else $error("Timeout enable wrong");
  AST_DEB_TIME: assert property (@(posedge mclk) disable iff (!rst_n) // RQ7
    deb_wr |=> press_deb_ms == 6'((($past(req.wdata) & 8'h0f) + 8'h01) * 8'h02))
    else $error("Press debounce time wrong");
  AST_FIFO_LEVEL: assert property (@(posedge mclk) disable iff (!rst_n) // RQ9
    (fifo_n != 3'h0 && fifo_count >= {1'b0, fifo_n, 1'b0}) |=> int_pend)
    else $error("FIFO level interrupt missed");
  AST_TIME_OFF: assert property (@(posedge mclk) disable iff (!rst_n) // RQ8
    (time_n == 5'h00 && !fifo_hit && int_clear) |=> !int_pend)
    else $error("Disabled periodic source fired");
  AST_EITHER: assert property (@(posedge mclk) disable iff (!rst_n) // RQ10
    (time_hit || fifo_hit) |=> !int_n)
    else $error("Source did not assert interrupt");
  AST_RESET_IRQ: assert property (@(posedge mclk) // RQ11
    !rst_n |=> interrupt_setup == 8'h00)
    else $error("Interrupt setup not cleared at reset");
  AST_RELEASE_OUT: assert property (@(posedge mclk) disable iff (!rst_n) // RQ12
    cfg_wr |=> release_enable == $past(req.wdata[CFG_RELEASE_BIT]))
    else $error("Release enable wrong");

  // Checks that follow the register path, so a broken mask or priority shows up here
  // Each one leaves out the higher-priority sources so it only fires on a real fault
  AST_AUTOSLEEP: assert property (@(posedge mclk) disable iff (!rst_n) // RQ3
    (autosleep_ev && !cfg_wr && !pwm_cc_on) |=> !device_configuration[CFG_SLEEP_BIT])
    else $error("Autosleep did not clear sleep bit");
  AST_AUTOWAKE: assert property (@(posedge mclk) disable iff (!rst_n) // RQ13
    (keypress_ev && autowake && !autosleep_ev && !cfg_wr && !pwm_cc_on) |=> device_configuration[CFG_SLEEP_BIT])
    else $error("Keypress did not wake");
  AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (!rst_n) // RQ13
    cfg_wr |=> (device_configuration & ~CFG_WRITE_MASK) == 8'h00)
    else $error("Reserved configuration bit set");
  AST_DEB_REL: assert property (@(posedge mclk) disable iff (!rst_n) // RQ7
    deb_wr |=> release_deb_ms == 6'((($past(req.wdata) >> 4) + 8'h01) * 8'h02))
    else $error("Release debounce time wrong");
  AST_TIME_EVERY: assert property (@(posedge mclk) disable iff (!rst_n) // RQ8
    (tick && time_n == 5'h01 && !irq_wr) |=> int_pend)
    else $error("Periodic source missed a debounce cycle");
  AST_FIFO_OFF: assert property (@(posedge mclk) disable iff (!rst_n) // RQ9
    (fifo_n == 3'h0 && !time_hit && int_clear) |=> !int_pend)
    else $error("Disabled FIFO source fired");
  AST_INT_HOLD_MODE1: assert property (@(posedge mclk) disable iff (!rst_n) // RQ5
    (int_pend && int_mode && !fifo_read) |=> int_pend)
    else $error("Interrupt dropped without FIFO read");
  AST_INT_CLEAR_EMPTY: assert property (@(posedge mclk) disable iff (!rst_n) // RQ4
    (int_pend && !int_mode && fifo_empty && !time_hit && !fifo_hit) |=> !int_pend)
    else $error("Interrupt kept with FIFO empty");

  // Reset checks carry no disable so they see the reset edge itself
  AST_INT_RESET: assert property (@(posedge mclk) // RQ11
    !rst_n |=> int_n)
    else $error("Interrupt asserted after reset");
  AST_CFG_RESET: assert property (@(posedge mclk) // RQ12
    !rst_n |=> device_configuration == RST_DEVICE_CONFIGURATION)
    else $error("Configuration not at reset value");
endmodule // keyscan_config_irq_regs

// ===== pkg/keyscan_cfg_pkg.sv
// Register map, field positions, reset values and timing for the keyscan configuration block
package keyscan_cfg_pkg;
  localparam logic [7:0] OFF_DEVICE_CONFIGURATION = 8'h01;
  localparam logic [7:0] OFF_DEBOUNCE_TIMES       = 8'h02;
  localparam logic [7:0] OFF_INTERRUPT_SETUP      = 8'h03;
  // Configuration fields
  localparam int CFG_SLEEP_BIT    = 7;
  localparam int CFG_INTMODE_BIT  = 5;
  localparam int CFG_RELEASE_BIT  = 3;
  localparam int CFG_AUTOWAKE_BIT = 1;
  localparam int CFG_TODIS_BIT    = 0;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hab;   // Reserved D6, D4, D2 read zero
  // Reset values
  localparam logic [7:0] RST_DEVICE_CONFIGURATION = 8'h0b;
  localparam logic [7:0] RST_DEBOUNCE_TIMES       = 8'hff;
  localparam logic [7:0] RST_INTERRUPT_SETUP      = 8'h00;
  // Timing: one debounce step is 2 ms
  localparam int CLK_HZ        = 10_000_000;
  localparam int DEB_STEP_MS   = 2;
  localparam int DEB_STEP_CYC  = CLK_HZ / 1000 * DEB_STEP_MS;
  localparam int FIFO_CNT_W    = 5;

  // Register access strobe bundle
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

// ===== verification/host_model.sv
// Host-side register master model driving the decoded access strobes
`timescale 1ns/1ps
module host_model
  import keyscan_cfg_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic [7:0] rdata,
  output reg_req_t        req
);
  initial req = '{1'b0, 1'b0, 8'h00, 8'h00};
  // One-cycle write; data inverted after so stale bytes never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    req = '{1'b1, 1'b0, a, d};
    @(negedge mclk);
    req = '{1'b0, 1'b0, a, ~d};
  endtask
  // Read strobe held across one edge, data taken at that edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk);
    d = rdata;
    @(negedge mclk);
    req.rd = 1'b0;
  endtask
endmodule // host_model

// ===== verification/tb_top.sv
// Self-checking bench for the keyscan configuration and interrupt registers
`timescale 1ns/1ps
module tb_top
  import keyscan_cfg_pkg::*;
;
  logic mclk = 0, rst_n = 0, pwm = 0, asl = 0, kp = 0, frd = 0, slp, ka, toe, rel, int_n, tck;
  logic [4:0] fcnt = 5'h00;
  logic [5:0] pms, rms;
  logic [7:0] rdata, v;
  reg_req_t req;
  int failures = 0, checks_done = 0, n;
  // Short divider keeps the debounce period at 8 cycles
  keyscan_config_irq_regs #(.STEP_CYC(8)) dut (.mclk(mclk), .rst_n(rst_n), .req(req), .rdata(rdata),
    .pwm_cc_on(pwm), .autosleep_ev(asl), .keypress_ev(kp), .fifo_read(frd), .fifo_count(fcnt),
    .chip_sleep(slp), .keys_active(ka), .bus_timeout_en(toe), .release_enable(rel),
    .press_deb_ms(pms), .release_deb_ms(rms), .debounce_tick_o(tck), .int_n(int_n));
  host_model host (.mclk(mclk), .rdata(rdata), .req(req));
  initial forever #50 mclk = ~mclk;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, v);
    chk(v, e);
  endtask
  // Bounded wait for the interrupt line to reach a level
  task automatic wi(input logic l, input int m);
    n = 0;
    while (int_n !== l && n < m) begin
      @(negedge mclk);
      n++;
    end
    chk({7'h0, int_n}, {7'h0, l});
  endtask
  task automatic hold(input int c);
    repeat (c) @(negedge mclk);
  endtask
  // Cycles from one debounce tick to the next
  task automatic tk;
    while (tck !== 1'b1) @(negedge mclk);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (tck !== 1'b1 && n < 20);
    chk(n[7:0], 8'd8);
  endtask
  task automatic t_regs;
    rc(OFF_DEBOUNCE_TIMES, 8'hff);
    rc(OFF_INTERRUPT_SETUP, 8'h00);
    chk({2'h0, pms}, 8'h20);
    tk;
    host.wr(8'h04, 8'h55);
    rc(8'h04, 8'h00);
    host.wr(OFF_DEVICE_CONFIGURATION, 8'hff);
    rc(OFF_DEVICE_CONFIGURATION, 8'hab);
    chk({6'h0, toe, rel}, 8'h01);
    host.wr(OFF_DEVICE_CONFIGURATION, 8'h00);
    chk({6'h0, toe, rel}, 8'h02);
    host.wr(OFF_DEBOUNCE_TIMES, 8'h3a);
    chk({2'h0, pms}, 8'h16);
    chk({2'h0, rms}, 8'h08);
    $display("test regs done");
  endtask
  task automatic t_sleep;
    host.wr(OFF_DEVICE_CONFIGURATION, 8'h0b);
    chk({6'h0, slp, ka}, 8'h02);
    pwm = 1;
    host.wr(OFF_DEVICE_CONFIGURATION, 8'h8b);
    rc(OFF_DEVICE_CONFIGURATION, 8'h0b);
    chk({6'h0, slp, ka}, 8'h01);
    pwm = 0;
    host.wr(OFF_DEVICE_CONFIGURATION, 8'h8b);
    rc(OFF_DEVICE_CONFIGURATION, 8'h8b);
    asl = 1;
    hold(1);
    asl = 0;
    rc(OFF_DEVICE_CONFIGURATION, 8'h0b);
    kp = 1;
    hold(1);
    kp = 0;
    rc(OFF_DEVICE_CONFIGURATION, 8'h8b);
    host.wr(OFF_DEVICE_CONFIGURATION, 8'h09);
    kp = 1;
    hold(1);
    kp = 0;
    rc(OFF_DEVICE_CONFIGURATION, 8'h09);
    $display("test sleep done");
  endtask
  task automatic t_irq;
    host.wr(OFF_DEVICE_CONFIGURATION, 8'h0b);
    host.wr(OFF_INTERRUPT_SETUP, 8'h03);
    wi(1'b0, 40);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (int_n !== 1'b0 && n < 60);
    chk(n[7:0], 8'd24);
    host.wr(OFF_INTERRUPT_SETUP, 8'he0);
    fcnt = 5'd13;
    hold(30);
    chk({7'h0, int_n}, 8'h01);
    fcnt = 5'd14;
    wi(1'b0, 4);
    fcnt = 5'd1;
    hold(20);
    chk({7'h0, int_n}, 8'h00);
    fcnt = 5'd0;
    wi(1'b1, 4);
    host.wr(OFF_DEVICE_CONFIGURATION, 8'h2b);
    fcnt = 5'd14;
    wi(1'b0, 4);
    fcnt = 5'd13;
    hold(10);
    chk({7'h0, int_n}, 8'h00);
    frd = 1;
    hold(1);
    frd = 0;
    wi(1'b1, 4);
    fcnt = 5'd0;
    host.wr(OFF_DEVICE_CONFIGURATION, 8'h0b);
    host.wr(OFF_INTERRUPT_SETUP, 8'h3f);
    wi(1'b0, 270);
    wi(1'b1, 4);
    fcnt = 5'd2;
    wi(1'b0, 4);
    fcnt = 5'd0;
    host.wr(OFF_INTERRUPT_SETUP, 8'h21);
    wi(1'b0, 20);
    fcnt = 5'd2;
    hold(20);
    chk({7'h0, int_n}, 8'h00);
    $display("test irq done");
  endtask
  task automatic final_report;
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    hold(2);
    rst_n = 1;
    t_regs;
    t_sleep;
    t_irq;
    final_report;
  end
  // Watchdog well beyond the roughly 500 cycles the tests need
  initial begin
    #1_000_000;
    failures++;
    final_report;
  end
endmodule // tb_top
